// *** inc/alarm_defines.vh ***
`ifndef ALARM_DEFINES_VH
`define ALARM_DEFINES_VH

// reaction codes
`define REACT_IGNORE 3'h0
`define REACT_WARNING 3'h1
`define REACT_DISABLE 3'h2
`define REACT_FAST_STOP 3'h3
`define REACT_STOP 3'h4
`define REACT_LIMIT_STOP 3'h5

// allowed-reaction masks, bit n allows code n
`define ALLOW_ALL 6'h3f
`define ALLOW_DISABLE_ONLY 6'h04
`define ALLOW_NO_STOP 6'h07
`define ALLOW_NO_SIGNAL 6'h3c
`define ALLOW_IGN_DIS 6'h05

// alarm indices
`define ALM_SUPPLY 0
`define ALM_UNDERVOLT 1
`define ALM_OVERVOLT 2
`define ALM_OVERSPEED 3
`define ALM_HEATSINK 4
`define ALM_OVERCURR 10
`define ALM_FIELD_LOSS 11
`define ALM_FREQ_DELTA 12
`define ALM_SPD_FBK_LOSS 13
`define ALM_ENABLE_SEQ 15
`define ALM_SUSTAINED 16

// register indices, byte address is four times the index
`define IDX_FS_HOLD 14'h1388
`define IDX_FS_RELAY 14'h138a
`define IDX_CFG_BASE 14'h1400
`define IDX_THR_UV 14'h1420
`define IDX_THR_OV 14'h1421
`define IDX_THR_OS 14'h1422
`define IDX_THR_OC 14'h1423
`define IDX_STATUS 14'h1430
`define IDX_FAULT 14'h1431
`define IDX_CMD 14'h1432
`define IDX_DOUT_SEL 14'h1433

// config word fields
`define CFG_REACT_LSB 0
`define CFG_LATCH_BIT 3
`define CFG_RELAY_BIT 4
`define CFG_HOLD_LSB 8
`define CFG_RESTART_LSB 16

// reset values
`define CFG_RESET 24'h000002
`define FS_HOLD_RESET 1'h0
`define FS_RELAY_RESET 1'h0
`define THR_LOW_RESET 16'h0000
`define THR_HIGH_RESET 16'hffff
`define DOUT_SEL_RESET 20'hfffff
`define DOUT_SEL_OFF 5'h1f

// timing
`define TICK_TIME_NS 1000000
`define CLK_PERIOD_NS 10

`endif

// *** rtl/pin_sync.v ***
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // pin and clean level
  input wire pin,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // change accepted only when second and third stage agree
  always @(posedge ref_clk) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

// *** rtl/alarm_channel.v ***
`timescale 1ns/1ps
module alarm_channel #(
  parameter HOLD_W = 8,
  parameter RESTART_W = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // timing base and settings
  input wire tick,
  input wire [HOLD_W-1:0] holdoff,
  input wire [RESTART_W-1:0] restart,
  input wire latch,
  // condition and manual reset
  input wire cond,
  input wire reset_req,
  // results
  output reg fault_q,
  output reg status_q
);
  reg [HOLD_W-1:0] hold_cnt_q;
  reg [RESTART_W-1:0] win_cnt_q;
  reg expired_q;
  wire qualified;
  wire win_over;
  wire clear_ok;

  assign qualified = cond && (hold_cnt_q >= holdoff);
  // zero restart time means no window: clearing always allows restart
  assign win_over = (restart != {RESTART_W{1'b0}}) && (win_cnt_q >= restart);
  // reset honoured only while condition is inactive
  assign clear_ok = !cond && reset_req;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      hold_cnt_q <= {HOLD_W{1'b0}};
      win_cnt_q <= {RESTART_W{1'b0}};
      expired_q <= 1'b0;
      fault_q <= 1'b0;
      status_q <= 1'b0;
    end else begin
      // short episode discarded entirely
      if (!cond) begin
        hold_cnt_q <= {HOLD_W{1'b0}};
      end else if (tick && hold_cnt_q < holdoff) begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end
      if (!fault_q) begin
        win_cnt_q <= {RESTART_W{1'b0}};
      end else if (tick && cond && !win_over) begin
        win_cnt_q <= win_cnt_q + 1'b1;
      end
      if (!fault_q) begin
        expired_q <= 1'b0;
      end else if (cond && win_over) begin
        expired_q <= 1'b1;
      end
      // set wins over any clear in the same cycle
      if (qualified) begin
        fault_q <= 1'b1;
      end else if (!cond && !latch && !expired_q && !(win_over && fault_q)) begin
        fault_q <= 1'b0;
      end else if (clear_ok) begin
        fault_q <= 1'b0;
      end
      if (qualified) begin
        status_q <= 1'b1;
      end else if (!cond && !latch) begin
        status_q <= 1'b0;
      end else if (clear_ok) begin
        status_q <= 1'b0;
      end
    end
  end
endmodule

// *** rtl/drive_alarm_manager.v ***
// How it works
// - each alarm selects reaction code 0..5: ignore, warning, disable, fast, stop, limit.
// - ignore shows nothing, drives nothing, but status output holds until reset; the code still drops the relay if the relay-open option is set.
// - warning raises the message, drive enable and ramps untouched.
// - disable raises message and drops drive enable immediately.
// - fast stop uses fast ramp, enable drops at zero speed.
// - stop uses active decel ramp, enable drops at zero speed.
// - limit stop brakes at torque limits bypassing ramps, enable drops at zero speed.
// - supply, undervoltage and field loss always disable.
// - overvoltage, overcurrent, frequency delta, feedback loss allow ignore, warning, disable.
// - heatsink no ignore/warning; enable-seq, sustained ignore/disable; rest all six.
// - status reaches a digital output whatever the reaction.
// - alarm acts only after condition holds continuously for the holdoff time.
// - latch off: auto re-enable only if condition clears within restart window.
// - latch on: restart needs condition cleared plus keypad or input reset.
// - latch off: status output drops as soon as condition clears.
// - latch on: status output stays until cleared and manually reset.
// - relay-open option drops the drive-healthy relay when the alarm triggers.
// - measured-quantity alarms trigger on crossing a programmable threshold.
// - supply alarm on internal fault or aux supply loss while enabled.
// - supply alarm reaction fixed, its latch set by the restart-mode register.
// - supply alarm relay drop has its own enable register.
// - any alarm status selectable onto any programmable digital output.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "alarm_defines.vh"
module drive_alarm_manager #(
  parameter NUM_ALARMS = 17,
  parameter NUM_DOUT = 4,
  parameter HOLD_W = 8,
  parameter RESTART_W = 8,
  parameter TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // ahb-lite slave
  input wire hsel,
  input wire [15:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // pins
  input wire supply_fault_pin,
  input wire aux_supply_terminals_ok,
  input wire keypad_reset_key,
  input wire alarm_reset_din,
  // alarm sources and measurements
  input wire [NUM_ALARMS-1:0] alarm_cond_in,
  input wire [15:0] mains_voltage,
  input wire [15:0] armature_voltage,
  input wire [15:0] speed_magnitude,
  input wire [15:0] armature_current,
  // drive state
  input wire run_request,
  input wire converter_enabled,
  input wire zero_speed,
  // drive control
  output reg drive_enable_q,
  output reg fast_stop_ramp_q,
  output reg normal_stop_ramp_q,
  output reg limit_brake_q,
  output reg alarm_message_q,
  output reg drive_ok_relay_q,
  // status outputs
  output wire [NUM_ALARMS-1:0] alarm_status,
  output reg [NUM_DOUT-1:0] dout_q
);
  reg [23:0] cfg_q [0:NUM_ALARMS-1];
  reg supply_fault_hold_q;
  reg supply_fault_relay_drop_q;
  reg [15:0] thr_uv_q;
  reg [15:0] thr_ov_q;
  reg [15:0] thr_os_q;
  reg [15:0] thr_oc_q;
  reg [5*NUM_DOUT-1:0] dout_sel_q;
  reg wr_pend_q;
  reg rd_wait_q;
  reg [13:0] idx_q;
  reg sw_reset_q;
  reg [16:0] tick_cnt_q;
  reg tick_q;
  reg reset_prev_q;
  reg stopped_q;
  wire [3:0] pin_lvl;
  wire reset_level;
  wire manual_reset;
  wire addr_phase;
  wire [NUM_ALARMS-1:0] cond;
  wire [NUM_ALARMS-1:0] fault;
  wire [NUM_ALARMS-1:0] msg_v;
  wire [NUM_ALARMS-1:0] dis_v;
  wire [NUM_ALARMS-1:0] fs_v;
  wire [NUM_ALARMS-1:0] st_v;
  wire [NUM_ALARMS-1:0] lim_v;
  wire [NUM_ALARMS-1:0] relay_v;
  wire any_dis;
  wire any_stop;
  reg [31:0] rd_mux;
  integer k;

  function [5:0] allowed;
    input integer i;
    begin
      case (i)
        `ALM_SUPPLY, `ALM_UNDERVOLT, `ALM_FIELD_LOSS: allowed = `ALLOW_DISABLE_ONLY;
        `ALM_OVERVOLT, `ALM_OVERCURR, `ALM_FREQ_DELTA, `ALM_SPD_FBK_LOSS: allowed = `ALLOW_NO_STOP;
        `ALM_HEATSINK: allowed = `ALLOW_NO_SIGNAL;
        `ALM_ENABLE_SEQ, `ALM_SUSTAINED: allowed = `ALLOW_IGN_DIS;
        default: allowed = `ALLOW_ALL;
      endcase
    end
  endfunction

  // a code that is not offered falls back to disable, the safe choice
  function [2:0] eff_react;
    input integer i;
    input [2:0] code;
    reg [5:0] m;
    begin
      m = allowed(i);
      if (code <= `REACT_LIMIT_STOP && m[code]) begin
        eff_react = code;
      end else begin
        eff_react = `REACT_DISABLE;
      end
    end
  endfunction

  // pins: keypad, reset input, supply fault, aux loss; loss is synced so reset level reads as present
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      pin_sync u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin(g == 0 ? keypad_reset_key : g == 1 ? alarm_reset_din : g == 2 ? supply_fault_pin
             : !aux_supply_terminals_ok),
        .level_q(pin_lvl[g])
      );
    end
  endgenerate

  assign reset_level = pin_lvl[0] | pin_lvl[1];
  // edge of either reset source, or a software reset write
  assign manual_reset = (reset_level && !reset_prev_q) || sw_reset_q;

  // millisecond time base for holdoff and restart windows
  always @(posedge ref_clk) begin
    if (!nrst) begin
      tick_cnt_q <= 17'h00000;
      tick_q <= 1'b0;
      reset_prev_q <= 1'b0;
    end else begin
      reset_prev_q <= reset_level;
      tick_q <= (tick_cnt_q == TICK_CYCLES[16:0] - 17'h00001);
      if (tick_cnt_q == TICK_CYCLES[16:0] - 17'h00001) begin
        tick_cnt_q <= 17'h00000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 17'h00001;
      end
    end
  end

  // alarm conditions
  generate
    for (g = 0; g < NUM_ALARMS; g = g + 1) begin : g_cond
      if (g == `ALM_SUPPLY) begin : g_fs
        assign cond[g] = pin_lvl[2] | (pin_lvl[3] & converter_enabled);
      end else if (g == `ALM_UNDERVOLT) begin : g_uv
        assign cond[g] = converter_enabled & (mains_voltage < thr_uv_q);
      end else if (g == `ALM_OVERVOLT) begin : g_ov
        assign cond[g] = converter_enabled & (armature_voltage > thr_ov_q);
      end else if (g == `ALM_OVERSPEED) begin : g_os
        assign cond[g] = converter_enabled & (speed_magnitude > thr_os_q);
      end else if (g == `ALM_OVERCURR) begin : g_oc
        assign cond[g] = armature_current > thr_oc_q;
      end else begin : g_ext
        assign cond[g] = alarm_cond_in[g];
      end
    end
  endgenerate

  // one channel per alarm plus its reaction decode
  generate
    for (g = 0; g < NUM_ALARMS; g = g + 1) begin : g_alm
      wire [2:0] react;
      wire latch_cfg;
      wire relay_en;
      assign react = eff_react(g, cfg_q[g][`CFG_REACT_LSB+2:`CFG_REACT_LSB]);
      assign latch_cfg = (g == `ALM_SUPPLY) ? supply_fault_hold_q : cfg_q[g][`CFG_LATCH_BIT];
      assign relay_en = (g == `ALM_SUPPLY) ? supply_fault_relay_drop_q : cfg_q[g][`CFG_RELAY_BIT];
      alarm_channel #(
        .HOLD_W(HOLD_W),
        .RESTART_W(RESTART_W)
      ) u_chan (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(tick_q),
        .holdoff(cfg_q[g][`CFG_HOLD_LSB+HOLD_W-1:`CFG_HOLD_LSB]),
        .restart(cfg_q[g][`CFG_RESTART_LSB+RESTART_W-1:`CFG_RESTART_LSB]),
        // ignore keeps its output until a reset after clearing
        .latch(latch_cfg | (react == `REACT_IGNORE)),
        .cond(cond[g]),
        .reset_req(manual_reset),
        .fault_q(fault[g]),
        .status_q(alarm_status[g])
      );
      assign msg_v[g] = fault[g] & (react != `REACT_IGNORE);
      assign dis_v[g] = fault[g] & (react == `REACT_DISABLE);
      assign fs_v[g] = fault[g] & (react == `REACT_FAST_STOP);
      assign st_v[g] = fault[g] & (react == `REACT_STOP);
      assign lim_v[g] = fault[g] & (react == `REACT_LIMIT_STOP);
      assign relay_v[g] = fault[g] & relay_en;
    end
  endgenerate

  assign any_dis = |dis_v;
  assign any_stop = |fs_v | |st_v | |lim_v;

  // drive control, disable overrides any controlled stop in progress
  always @(posedge ref_clk) begin
    if (!nrst) begin
      stopped_q <= 1'b0;
      drive_enable_q <= 1'b0;
      fast_stop_ramp_q <= 1'b0;
      normal_stop_ramp_q <= 1'b0;
      limit_brake_q <= 1'b0;
      alarm_message_q <= 1'b0;
      drive_ok_relay_q <= 1'b0;
      dout_q <= {NUM_DOUT{1'b0}};
    end else begin
      if (!any_stop) begin
        stopped_q <= 1'b0;
      end else if (zero_speed) begin
        stopped_q <= 1'b1;
      end
      drive_enable_q <= run_request & !any_dis & !stopped_q & !(any_stop & zero_speed);
      limit_brake_q <= !any_dis & (|lim_v);
      fast_stop_ramp_q <= !any_dis & !(|lim_v) & (|fs_v);
      normal_stop_ramp_q <= !any_dis & !(|lim_v) & !(|fs_v) & (|st_v);
      alarm_message_q <= |msg_v;
      drive_ok_relay_q <= !(|relay_v);
      for (k = 0; k < NUM_DOUT; k = k + 1) begin
        if (dout_sel_q[5*k +: 5] < NUM_ALARMS) begin
          dout_q[k] <= alarm_status[dout_sel_q[5*k +: 5]];
        end else begin
          dout_q[k] <= 1'b0;
        end
      end
    end
  end

  // bus: writes finish in their data phase, reads add one wait state
  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout = !rd_wait_q;
  assign hresp = 1'b0;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
      idx_q <= 14'h0000;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      rd_wait_q <= addr_phase && !hwrite;
      if (addr_phase) begin
        idx_q <= haddr[15:2];
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      for (k = 0; k < NUM_ALARMS; k = k + 1) begin
        cfg_q[k] <= `CFG_RESET;
      end
      supply_fault_hold_q <= `FS_HOLD_RESET;
      supply_fault_relay_drop_q <= `FS_RELAY_RESET;
      thr_uv_q <= `THR_LOW_RESET;
      thr_ov_q <= `THR_HIGH_RESET;
      thr_os_q <= `THR_HIGH_RESET;
      thr_oc_q <= `THR_HIGH_RESET;
      dout_sel_q <= `DOUT_SEL_RESET;
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= 1'b0;
      if (wr_pend_q) begin
        for (k = 0; k < NUM_ALARMS; k = k + 1) begin
          if (idx_q == `IDX_CFG_BASE + k[13:0]) begin
            cfg_q[k] <= hwdata[23:0];
          end
        end
        case (idx_q)
          `IDX_FS_HOLD: supply_fault_hold_q <= hwdata[0];
          `IDX_FS_RELAY: supply_fault_relay_drop_q <= hwdata[0];
          `IDX_THR_UV: thr_uv_q <= hwdata[15:0];
          `IDX_THR_OV: thr_ov_q <= hwdata[15:0];
          `IDX_THR_OS: thr_os_q <= hwdata[15:0];
          `IDX_THR_OC: thr_oc_q <= hwdata[15:0];
          `IDX_DOUT_SEL: dout_sel_q <= hwdata[5*NUM_DOUT-1:0];
          `IDX_CMD: sw_reset_q <= hwdata[0];
          default: sw_reset_q <= 1'b0;
        endcase
      end
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    for (k = 0; k < NUM_ALARMS; k = k + 1) begin
      if (idx_q == `IDX_CFG_BASE + k[13:0]) begin
        rd_mux = {8'h00, cfg_q[k]};
      end
    end
    case (idx_q)
      `IDX_FS_HOLD: rd_mux = {31'h00000000, supply_fault_hold_q};
      `IDX_FS_RELAY: rd_mux = {31'h00000000, supply_fault_relay_drop_q};
      `IDX_THR_UV: rd_mux = {16'h0000, thr_uv_q};
      `IDX_THR_OV: rd_mux = {16'h0000, thr_ov_q};
      `IDX_THR_OS: rd_mux = {16'h0000, thr_os_q};
      `IDX_THR_OC: rd_mux = {16'h0000, thr_oc_q};
      `IDX_DOUT_SEL: rd_mux = {{(32-5*NUM_DOUT){1'b0}}, dout_sel_q};
      `IDX_STATUS: rd_mux = {{(32-NUM_ALARMS){1'b0}}, alarm_status};
      `IDX_FAULT: rd_mux = {{(32-NUM_ALARMS){1'b0}}, fault};
      default: rd_mux = rd_mux;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (rd_wait_q) begin
      hrdata <= rd_mux;
    end
  end
endmodule

// *** tb/alarm_mgr_sva.sv ***
`timescale 1ns/1ps
module alarm_mgr_sva #(
  parameter NUM_ALARMS = 17
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  // pins and drive state
  input wire supply_fault_pin,
  input wire zero_speed,
  // drive control and status
  input wire drive_enable_q,
  input wire fast_stop_ramp_q,
  input wire normal_stop_ramp_q,
  input wire limit_brake_q,
  input wire alarm_message_q,
  input wire drive_ok_relay_q,
  input wire [NUM_ALARMS-1:0] alarm_status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire take = hsel && hready && htrans[1];
  wire stopping = fast_stop_ramp_q || normal_stop_ramp_q || limit_brake_q;

  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_ramp_onehot: assert property ($onehot0({fast_stop_ramp_q, normal_stop_ramp_q, limit_brake_q}))
    else $error("more than one stop style active");
  a_stop_zero: assert property (stopping && zero_speed |=> !drive_enable_q)
    else $error("enable kept after zero speed in a stop");
  a_supply_disable: assert property ($rose(alarm_status[0]) |=> !drive_enable_q && alarm_message_q)
    else $error("supply alarm did not disable with message");
  a_supply_hold: assert property (alarm_status[0] && $past(alarm_status[0]) |-> !drive_enable_q)
    else $error("drive enabled during supply alarm");
  a_supply_pin: assert property (supply_fault_pin [*6] |-> ##[0:2] alarm_status[0])
    else $error("supply fault pin not reported");
  a_relay_cause: assert property ($fell(drive_ok_relay_q) |-> (|alarm_status) || $past(|alarm_status))
    else $error("healthy relay opened without an alarm");

  c_read: cover property (take && !hwrite);
  c_stop_done: cover property (stopping && zero_speed);
  c_relay_drop: cover property ($fell(drive_ok_relay_q));
endmodule

bind drive_alarm_manager alarm_mgr_sva #(.NUM_ALARMS(NUM_ALARMS)) u_sva (.ref_clk, .nrst, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .supply_fault_pin, .zero_speed, .drive_enable_q, .fast_stop_ramp_q,
  .normal_stop_ramp_q, .limit_brake_q, .alarm_message_q, .drive_ok_relay_q, .alarm_status);

// *** tb/drive_side_model.sv ***
`timescale 1ns/1ps
module drive_side_model (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // control from the block
  input wire drive_enable_q,
  input wire stopping,
  input wire [7:0] decel,
  // motor state
  output logic zero_speed
);
  // motor slows while stopping or coasting, so zero speed comes late on purpose
  int n;
  always @(posedge ref_clk) begin
    if (!nrst || (drive_enable_q && !stopping)) begin
      n <= 0;
      zero_speed <= 1'b0;
    end else begin
      n <= n + 1;
      zero_speed <= (n + 1 >= decel);
    end
  end
endmodule

// *** tb/drive_alarm_manager_tb.sv ***
`timescale 1ns/1ps
module drive_alarm_manager_tb;
  logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, q;
  logic sf_pin = 0, aux_ok = 1, kp_rst = 0, din_rst = 0, run = 1, conv = 1;
  logic [16:0] cond = 17'h0;
  logic [15:0] mains = 16'h00c8;
  logic [15:0] meas = 16'h0000;
  int m;
  logic [7:0] decel = 8'h05;
  wire hready, zs, en, fs, ns, lb, msg, relay, resp;
  wire [31:0] hrdata;
  wire [16:0] st;
  wire [3:0] dout;
  int bad_count = 0, checked = 0;
  // allowed reactions per alarm, bit n allows code n
  int allow[17] = '{4, 4, 7, 63, 60, 63, 63, 63, 63, 63, 7, 4, 7, 7, 63, 5, 5};
  int al[12] = '{5, 5, 5, 5, 5, 5, 4, 15, 12, 11, 16, 14};
  int cd[12] = '{0, 1, 2, 3, 4, 5, 0, 1, 3, 5, 0, 4};

  always #5 ref_clk = ~ref_clk;

  drive_alarm_manager #(.TICK_CYCLES(4)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(resp), .hrdata(hrdata),
    .supply_fault_pin(sf_pin), .aux_supply_terminals_ok(aux_ok), .keypad_reset_key(kp_rst),
    .alarm_reset_din(din_rst), .alarm_cond_in(cond), .mains_voltage(mains), .armature_voltage(meas),
    .speed_magnitude(meas), .armature_current(meas), .run_request(run), .converter_enabled(conv),
    .zero_speed(zs), .drive_enable_q(en), .fast_stop_ramp_q(fs), .normal_stop_ramp_q(ns),
    .limit_brake_q(lb), .alarm_message_q(msg), .drive_ok_relay_q(relay), .alarm_status(st), .dout_q(dout)
  );

  drive_side_model u_drive (.ref_clk(ref_clk), .nrst(nrst), .drive_enable_q(en), .stopping(fs | ns | lb),
    .decel(decel), .zero_speed(zs));

  task report_and_stop;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // values read at the edge are the ones settled before it
  task xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task rd_chk(input logic [15:0] a, input logic [31:0] exp, input string m);
    xfer(a, 1'b0, 32'h0);
    chk(q, exp, m);
    chk(resp, 0, "okay response");
  endtask

  task react(input int a, input int c);
    int e;
    e = allow[a][c] ? c : 2;
    xfer(16'(20480 + 4 * a), 1'b1, 32'(c));
    decel <= 8'($urandom_range(1, 12));
    cond[a] <= 1'b1;
    cyc(3);
    chk(msg, e != 0, "message");
    chk(en, e != 2, "enable at alarm");
    chk({fs, ns, lb}, {e == 3, e == 4, e == 5}, "stop style");
    chk(dout, {3'b000, a == 5}, "digital outputs");
    cyc(20);
    chk(en, e < 2, "enable after stop");
    cond[a] <= 1'b0;
    cyc(3);
    chk(st[a], e == 0, "status after clear");
    xfer(16'h50c8, 1'b1, 32'h1);
    cyc(3);
    chk(st[a], 0, "status after reset");
    chk(en, 1, "restart");
    xfer(16'(20480 + 4 * a), 1'b1, 32'h2);
  endtask

  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end

  initial begin
    void'($urandom(41));
    cyc(20);
    nrst <= 1;
    cyc(1);
    rd_chk(16'h5014, 32'h2, "config reset");
    rd_chk(16'h4e20, 32'h0, "hold reset");
    rd_chk(16'h5084, 32'hffff, "threshold reset");
    rd_chk(16'h6000, 32'h0, "unmapped");
    xfer(16'h4e28, 1'b1, 32'h1);
    rd_chk(16'h4e28, 32'h1, "relay drop rw");
    xfer(16'h50cc, 1'b1, 32'hfffe5);
    for (int k = 0; k < 12; k++) react(al[k], cd[k]);
    xfer(16'h5018, 1'b1, 32'h302);
    cond[6] <= 1'b1;
    cyc($urandom_range(1, 7));
    cond[6] <= 1'b0;
    cyc(20);
    chk(st[6], 0, "short episode");
    cond[6] <= 1'b1;
    cyc(24);
    chk(st[6], 1, "held episode");
    cond[6] <= 1'b0;
    xfer(16'h5018, 1'b1, 32'h20012);
    cond[6] <= 1'b1;
    cyc(20);
    cond[6] <= 1'b0;
    cyc(4);
    chk({st[6], en, relay}, 3'b000, "window expired");
    rd_chk(16'h50c4, 32'h40, "fault word");
    xfer(16'h50c8, 1'b1, 32'h1);
    cyc(3);
    chk({en, relay}, 2'b11, "reset after window");
    xfer(16'h5018, 1'b1, 32'h2);
    xfer(16'h4e20, 1'b1, 32'h1);
    sf_pin <= 1;
    cyc(8);
    chk({st[0], en, relay}, 3'b100, "supply alarm");
    kp_rst <= 1;
    cyc(6);
    kp_rst <= 0;
    cyc(6);
    chk(st[0], 1, "reset while active");
    sf_pin <= 0;
    cyc(10);
    chk(st[0], 1, "latched");
    din_rst <= 1;
    cyc(6);
    din_rst <= 0;
    cyc(6);
    chk({st[0], en, relay}, 3'b011, "after manual reset");
    xfer(16'h4e20, 1'b1, 32'h0);
    aux_ok <= 0;
    cyc(8);
    chk(st[0], 1, "aux loss");
    aux_ok <= 1;
    cyc(8);
    chk({st[0], relay}, 2'b01, "auto clear");
    xfer(16'h5080, 1'b1, 32'h64);
    mains <= 16'($urandom_range(0, 99));
    cyc(4);
    chk(st[1], 1, "under threshold");
    mains <= 16'h00c8;
    cyc(4);
    chk(st[1], 0, "above threshold");
    for (int i = 0; i < 3; i++) xfer(16'(20612 + 4 * i), 1'b1, 32'(256 * (i + 1)));
    m = $urandom_range(257, 1023);
    meas <= 16'(m);
    cyc(4);
    chk({st[10], st[3], st[2]}, {m > 768, m > 512, 1'b1}, "measured trip");
    rd_chk(16'h50c0, {21'h000000, m > 768, 6'h00, m > 512, 3'h4}, "status word");
    meas <= 16'h0000;
    cyc(4);
    chk({st[10], st[3], st[2]}, 3'b000, "measured clear");
    report_and_stop;
  end
endmodule
